// File: logic/ilf_cmp.sv
// Compares two linear-format values and reports a below b.
// Assumes both values are stable in the cycle they are read.
module ilf_cmp
    import ilf_pkg::*;
(
    input wire ilf_lin_s a,     // Measured value
    input wire ilf_lin_s b,     // Threshold
    output logic below          // a is less than b
);
    // Both sides are scaled to one fixed point so differing exponents compare right
    function automatic logic signed [ILF_FIX_W-1:0] to_fix(input ilf_lin_s v);
        logic signed [ILF_FIX_W-1:0] m;
        logic signed [6:0] sh;
        m = ILF_FIX_W'(v.mant);
        sh = 7'(v.expo) + ILF_EXP_BIAS;
        return m <<< sh[5:0];
    endfunction : to_fix

    always_comb begin
        below = to_fix(a) < to_fix(b);
    end
endmodule : ilf_cmp

// File: logic/ilf_pkg.sv
// Constants, types and command codes for the input-low fault handler.
// Assumes one clock MCLK at 25 MHz and linear-format voltages on every threshold.
// What this block does
// - Hold the 16-bit linear warning threshold; it is also the hybrid switch-over level.
// - The hybrid switch-over acts only while the vendor option setting enables it.
// - Hold a separate 16-bit linear fault threshold.
// - Response 00 ignores the fault and keeps the output running.
// - Response 01 runs on for the delay, then follows the retry field if the fault persists.
// - Response 10 disables the output at once, then follows the retry field.
// - Response 11 keeps the output off until the fault is cleared.
// - Retry field 000 makes no restart and keeps the output off until cleared.
// - Retry fields 001 to 110 try one to six restarts, then latch off.
// - Restart attempts start one programmed delay apart.
// - Retry field 111 retries forever until commanded off or another fault.
// - Delay field n means two to the power n delay units.
// - One delay unit comes from the time-unit setting, for run-on and spacing.
package ilf_pkg;
    // ****************************************
    // Command codes and reset values
    // ****************************************
    localparam logic [7:0] ILF_CMD_WARN = 8'h58;
    localparam logic [7:0] ILF_CMD_FAULT = 8'h59;
    localparam logic [7:0] ILF_CMD_ACT = 8'h5A;
    localparam logic [7:0] ILF_CMD_OPT = 8'hE0;
    localparam logic [15:0] ILF_WARN_RST = 16'h0000;
    localparam logic [15:0] ILF_FAULT_RST = 16'h0000;
    localparam logic [7:0] ILF_ACT_RST = 8'hC0;
    localparam logic [7:0] ILF_OPT_RST = 8'h00;
    localparam logic [7:0] ILF_BYTE_PAD = 8'h00;
    localparam logic [15:0] ILF_RD_NONE = 16'h0000;
    localparam int ILF_OPT_HRR_BIT = 0;

    // ****************************************
    // Timing, retry codes and compare scaling
    // ****************************************
    localparam int ILF_CLK_NS = 40;
    localparam int ILF_MS_NS = 1000000;
    localparam int ILF_MS_CYC = ILF_MS_NS / ILF_CLK_NS;
    localparam logic [7:0] ILF_DLY_ONE = 8'h01;
    localparam logic [2:0] ILF_TRY_ONE = 3'h1;
    localparam logic [2:0] ILF_RETRY_NONE = 3'h0;
    localparam logic [2:0] ILF_RETRY_INF = 3'h7;
    localparam int ILF_FIX_W = 48;
    localparam logic signed [6:0] ILF_EXP_BIAS = 7'sh10;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        ILF_RESP_IGN = 2'h0,
        ILF_RESP_RUNON = 2'h1,
        ILF_RESP_DISRETRY = 2'h2,
        ILF_RESP_LATCH = 2'h3
    } ilf_resp_e;

    typedef enum logic [3:0] {
        ILF_S_RUN = 4'h1,
        ILF_S_DLY = 4'h2,
        ILF_S_WAIT = 4'h4,
        ILF_S_LATCH = 4'h8
    } ilf_state_e;

    typedef struct packed {
        ilf_resp_e resp;
        logic [2:0] retries;
        logic [2:0] delay;
    } ilf_act_s;

    typedef struct packed {
        logic signed [4:0] expo;
        logic signed [10:0] mant;
    } ilf_lin_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] code;
        logic [15:0] data;
    } ilf_cmd_s;
endpackage : ilf_pkg

// File: logic/ilf_tick.sv
// Delay-unit pacer: a millisecond prescaler and a unit counter.
// Assumes the unit length in ms is set by the time-unit configuration.
module ilf_tick
    import ilf_pkg::*;
#(
    parameter int MS_CYCLES = ILF_MS_CYC
) (
    input wire logic clk,           // System clock
    input wire logic rst_n,         // Async reset, active low
    input wire logic restart,       // Realign phase to a fresh unit
    input wire logic [7:0] unit_ms, // Unit length in ms, zero taken as one
    output logic tick               // One pulse per delay unit
);
    localparam int MW = $clog2(MS_CYCLES + 1);
    localparam logic [MW-1:0] MS_LAST = MW'(MS_CYCLES - 1);

    logic [MW-1:0] ms_q, ms_d;
    logic [7:0] unit_q, unit_d;
    logic tick_q, tick_d;
    logic ms_end;

    always_comb begin
        ms_end = ms_q == MS_LAST;
        ms_d = ms_end ? '0 : MW'(ms_q + 1'b1);
        unit_d = unit_q;
        tick_d = 1'b0;
        if (ms_end) begin
            if (8'(unit_q + ILF_DLY_ONE) >= unit_ms) begin
                unit_d = '0;
                tick_d = 1'b1;
            end else begin
                unit_d = 8'(unit_q + ILF_DLY_ONE);
            end
        end
        if (restart) begin
            ms_d = '0;
            unit_d = '0;
            tick_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ms_q <= '0;
            unit_q <= '0;
            tick_q <= 1'b0;
        end else begin
            ms_q <= ms_d;
            unit_q <= unit_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;

    a_tick_single: assert property (@(posedge clk) disable iff (!rst_n)
        tick_q |=> !tick_q)
        else $error("unit tick lasted more than one cycle");
endmodule : ilf_tick

// File: logic/ilf_top.sv
// Input-low supervision: thresholds, response byte, retry sequencer.
// Assumes a command port already decoded from the management bus and
// a measured input voltage in linear format, synchronous to MCLK.
module ilf_top
    import ilf_pkg::*;
#(
    parameter int MS_CYCLES = ILF_MS_CYC
) (
    input wire logic MCLK,             // 25 MHz clock
    input wire logic RESETN,           // Async reset, active low
    input wire ilf_cmd_s CMD,          // Command write/read strobes, code, data
    output logic [15:0] RD_DATA,       // Read answer
    output logic RD_VALID,             // Read answer pulse
    input wire ilf_lin_s VIN,          // Measured input voltage
    input wire logic CTRL_ON,          // Output commanded on (pin and/or command)
    input wire logic CLEAR_FAULTS,     // Clear-all pulse
    input wire logic CLEAR_UV_BIT,     // Clear of the input-low bit alone
    input wire logic OTHER_FAULT,      // Another fault forces shutdown
    input wire logic [7:0] TIME_UNIT_MS, // Length of one delay unit in ms
    output logic OUT_EN,               // Converter output enable
    output logic UV_WARN,              // Sticky input-low warning
    output logic UV_FAULT,             // Sticky input-low fault
    output logic HRR_SWITCH,           // Hybrid ratio switch-over request
    output logic LATCHED               // Held off until cleared
);
    // ****************************************
    // Command registers
    // ****************************************
    ilf_lin_s warn_thr_q, warn_thr_d;
    ilf_lin_s fault_thr_q, fault_thr_d;
    ilf_act_s act_q, act_d;
    logic [7:0] opt_q, opt_d;
    logic [15:0] rd_data_q, rd_data_d;
    logic rd_valid_q, rd_valid_d;

    always_comb begin
        warn_thr_d = warn_thr_q;
        fault_thr_d = fault_thr_q;
        act_d = act_q;
        opt_d = opt_q;
        if (CMD.wr) begin
            case (CMD.code)
                ILF_CMD_WARN: warn_thr_d = CMD.data;
                ILF_CMD_FAULT: fault_thr_d = CMD.data;
                ILF_CMD_ACT: act_d = CMD.data[7:0];
                ILF_CMD_OPT: opt_d = CMD.data[7:0];
                default: ;
            endcase
        end
        rd_valid_d = CMD.rd;
        rd_data_d = rd_data_q;
        if (CMD.rd) begin
            case (CMD.code)
                ILF_CMD_WARN: rd_data_d = warn_thr_q;
                ILF_CMD_FAULT: rd_data_d = fault_thr_q;
                ILF_CMD_ACT: rd_data_d = {ILF_BYTE_PAD, act_q};
                ILF_CMD_OPT: rd_data_d = {ILF_BYTE_PAD, opt_q};
                default: rd_data_d = ILF_RD_NONE;
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            warn_thr_q <= ILF_WARN_RST;
            fault_thr_q <= ILF_FAULT_RST;
            act_q <= ILF_ACT_RST;
            opt_q <= ILF_OPT_RST;
            rd_data_q <= ILF_RD_NONE;
            rd_valid_q <= 1'b0;
        end else begin
            warn_thr_q <= warn_thr_d;
            fault_thr_q <= fault_thr_d;
            act_q <= act_d;
            opt_q <= opt_d;
            rd_data_q <= rd_data_d;
            rd_valid_q <= rd_valid_d;
        end
    end

    // ****************************************
    // Threshold compare and status flags
    // ****************************************
    logic warn_now, fault_now, clr_any;
    logic warn_q, warn_d, fault_q, fault_d, hrr_q, hrr_d;

    ilf_cmp u_cmp_warn (
        .a(VIN),
        .b(warn_thr_q),
        .below(warn_now)
    );

    ilf_cmp u_cmp_fault (
        .a(VIN),
        .b(fault_thr_q),
        .below(fault_now)
    );

    // A new event in the clearing cycle must survive, so set wins
    always_comb begin
        clr_any = CLEAR_FAULTS || CLEAR_UV_BIT;
        warn_d = warn_now || (warn_q && !clr_any);
        fault_d = fault_now || (fault_q && !clr_any);
        hrr_d = opt_q[ILF_OPT_HRR_BIT] && warn_now;
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            warn_q <= 1'b0;
            fault_q <= 1'b0;
            hrr_q <= 1'b0;
        end else begin
            warn_q <= warn_d;
            fault_q <= fault_d;
            hrr_q <= hrr_d;
        end
    end

    // ****************************************
    // Response sequencer
    // ****************************************
    ilf_state_e st_q, st_d;
    logic [7:0] dly_q, dly_d;
    logic [2:0] tries_q, tries_d;
    logic off_seen_q, off_seen_d;
    logic out_en_q, out_en_d;
    logic latched_q, latched_d;
    logic load, unit_tick, dly_done, stop;

    ilf_tick #(
        .MS_CYCLES(MS_CYCLES)
    ) u_tick (
        .clk(MCLK),
        .rst_n(RESETN),
        .restart(load),
        .unit_ms(TIME_UNIT_MS),
        .tick(unit_tick)
    );

    always_comb begin
        st_d = st_q;
        dly_d = dly_q;
        tries_d = tries_q;
        off_seen_d = off_seen_q;
        load = 1'b0;
        dly_done = unit_tick && (dly_q == ILF_DLY_ONE);
        stop = !CTRL_ON || OTHER_FAULT;
        case (st_q)
            ILF_S_RUN: begin
                off_seen_d = 1'b0;
                if (fault_now && !stop) begin
                    case (act_q.resp)
                        ILF_RESP_IGN: ;
                        ILF_RESP_RUNON: begin
                            st_d = ILF_S_DLY;
                            load = 1'b1;
                        end
                        ILF_RESP_DISRETRY: begin
                            if (act_q.retries == ILF_RETRY_NONE) begin
                                st_d = ILF_S_LATCH;
                            end else begin
                                st_d = ILF_S_WAIT;
                                tries_d = act_q.retries;
                                load = 1'b1;
                            end
                        end
                        ILF_RESP_LATCH: st_d = ILF_S_LATCH;
                        default: ;
                    endcase
                end
            end
            ILF_S_DLY: begin
                if (stop) begin
                    st_d = ILF_S_RUN;
                end else if (dly_done) begin
                    if (!fault_now) begin
                        st_d = ILF_S_RUN;
                    end else if (act_q.retries == ILF_RETRY_NONE) begin
                        st_d = ILF_S_LATCH;
                    end else begin
                        st_d = ILF_S_WAIT;
                        tries_d = act_q.retries;
                        load = 1'b1;
                    end
                end
            end
            ILF_S_WAIT: begin
                // Commanded off or another fault ends the retry run
                if (stop) begin
                    st_d = ILF_S_RUN;
                end else if (dly_done) begin
                    if (!fault_now) begin
                        st_d = ILF_S_RUN;
                    end else if (tries_q == ILF_RETRY_INF) begin
                        load = 1'b1;
                    end else if (tries_q == ILF_TRY_ONE) begin
                        st_d = ILF_S_LATCH;
                    end else begin
                        tries_d = 3'(tries_q - ILF_TRY_ONE);
                        load = 1'b1;
                    end
                end
            end
            ILF_S_LATCH: begin
                // Off then on again counts as a clear
                if (clr_any || (off_seen_q && CTRL_ON)) begin
                    st_d = ILF_S_RUN;
                    off_seen_d = 1'b0;
                end else if (!CTRL_ON) begin
                    off_seen_d = 1'b1;
                end
            end
            default: st_d = ILF_S_LATCH;
        endcase
        if (load) begin
            dly_d = ILF_DLY_ONE << act_q.delay;
        end else if (unit_tick && dly_q != ILF_DLY_ONE) begin
            dly_d = 8'(dly_q - ILF_DLY_ONE);
        end
        out_en_d = !stop && (st_d == ILF_S_RUN || st_d == ILF_S_DLY);
        latched_d = st_d == ILF_S_LATCH;
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            st_q <= ILF_S_RUN;
            dly_q <= ILF_DLY_ONE;
            tries_q <= ILF_RETRY_NONE;
            off_seen_q <= 1'b0;
            out_en_q <= 1'b0;
            latched_q <= 1'b0;
        end else begin
            st_q <= st_d;
            dly_q <= dly_d;
            tries_q <= tries_d;
            off_seen_q <= off_seen_d;
            out_en_q <= out_en_d;
            latched_q <= latched_d;
        end
    end

    assign RD_DATA = rd_data_q;
    assign RD_VALID = rd_valid_q;
    assign OUT_EN = out_en_q;
    assign UV_WARN = warn_q;
    assign UV_FAULT = fault_q;
    assign HRR_SWITCH = hrr_q;
    assign LATCHED = latched_q;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RESETN);

    a_warn_thr_write: assert property (
        CMD.wr && CMD.code == ILF_CMD_WARN |=> warn_thr_q == $past(CMD.data))
        else $error("warning threshold not stored");
    a_hrr_gated: assert property (
        !opt_q[ILF_OPT_HRR_BIT] |=> !hrr_q)
        else $error("hybrid switch-over active while disabled");
    a_fault_thr_write: assert property (
        CMD.wr && CMD.code == ILF_CMD_FAULT |=> fault_thr_q == $past(CMD.data))
        else $error("fault threshold not stored");
    a_ignore_runs: assert property (
        st_q == ILF_S_RUN && act_q.resp == ILF_RESP_IGN && CTRL_ON && !OTHER_FAULT
        |=> st_q == ILF_S_RUN && out_en_q)
        else $error("ignored fault disturbed the output");
    a_runon_load: assert property (
        st_q == ILF_S_RUN && act_q.resp == ILF_RESP_RUNON && fault_now && !stop
        |=> st_q == ILF_S_DLY && out_en_q && dly_q == (ILF_DLY_ONE << $past(act_q.delay)))
        else $error("run-on delay not loaded");
    a_disable_now: assert property (
        st_q == ILF_S_RUN && act_q.resp == ILF_RESP_DISRETRY && fault_now && !stop
        |=> !out_en_q)
        else $error("output not disabled at once");
    a_latch_holds: assert property (
        st_q == ILF_S_LATCH && !clr_any && !CTRL_ON
        |=> st_q == ILF_S_LATCH && !out_en_q)
        else $error("latched off state left without a clear");
    a_no_retry: assert property (
        st_q == ILF_S_RUN && act_q.resp == ILF_RESP_DISRETRY && fault_now && !stop
        && act_q.retries == ILF_RETRY_NONE |=> st_q == ILF_S_LATCH)
        else $error("restart attempted with zero retries");
    a_retry_limit: assert property (
        st_q == ILF_S_WAIT && !stop && dly_done && fault_now && tries_q == ILF_TRY_ONE
        |=> st_q == ILF_S_LATCH)
        else $error("retry count exceeded");
    a_retry_forever: assert property (
        st_q == ILF_S_WAIT && !stop && dly_done && fault_now && tries_q == ILF_RETRY_INF
        |=> st_q == ILF_S_WAIT && tries_q == ILF_RETRY_INF)
        else $error("continuous retry stopped");
    a_warn_flag: assert property (
        warn_now |=> warn_q)
        else $error("warning flag missed");
    // A warning alone must never touch the output
    a_warn_keeps_output: assert property (
        st_q == ILF_S_RUN && warn_now && !fault_now && !stop |=> st_q == ILF_S_RUN && out_en_q)
        else $error("warning disturbed the output");
    a_fault_flag: assert property (
        fault_now |=> fault_q)
        else $error("fault flag missed");
endmodule : ilf_top

// File: tb/ilf_host.sv
// Host-side model that writes and reads the block's command registers.
// Assumes the command port takes a strobe at a rising clock edge.
module ilf_host
    import ilf_pkg::*;
(
    input wire logic clk, // Clock
    output ilf_cmd_s cmd, // Command strobes and payload
    input wire logic [15:0] rd_data, // Read answer
    input wire logic rd_valid // Read answer pulse
);
    timeunit 1ns;
    timeprecision 1ns;

    initial cmd = {1'b0, 1'b0, 8'h00, 16'h0000};

    // ****************************************
    // Command cycles
    // ****************************************
    // Idle payload shows the inverse of the last one, so a stale copy never matches
    task automatic write(input logic [7:0] code, input logic [15:0] data);
        @(posedge clk);
        cmd <= {1'b1, 1'b0, code, data};
        @(posedge clk);
        cmd <= {1'b0, 1'b0, ~code, ~data};
    endtask : write

    task automatic read(input logic [7:0] code, output logic [15:0] data, output logic valid);
        @(posedge clk);
        cmd <= {1'b0, 1'b1, code, 16'h0000};
        @(posedge clk);
        cmd <= {1'b0, 1'b0, ~code, 16'hFFFF};
        #1;
        data = rd_data;
        valid = rd_valid;
    endtask : read
endmodule : ilf_host

// File: tb/tb_ilf_top.sv
// Self-checking bench for the input-low fault handler.
// Assumes the host model ilf_host and a four-cycle millisecond in simulation.
module tb_ilf_top
    import ilf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int MSC = 4;
    localparam logic [15:0] V_OK = 16'h00C8;
    localparam logic [15:0] V_WRN = 16'h0828; // 40 x 2: below warning only
    localparam logic [15:0] V_BAD = 16'h0014;
    typedef struct packed {
        logic [7:0] act;
        logic [7:0] opt;
        logic [15:0] vin;
        logic [4:0] exp; // out_en, warn, fault, latched, hrr
    } ilf_row_s;
    ilf_row_s rows [8] = '{
        '{8'hC0, 8'h00, V_OK, 5'b10000}, '{8'hC0, 8'h00, V_WRN, 5'b11000},
        '{8'hC0, 8'h01, V_WRN, 5'b11001}, '{8'hC0, 8'h01, V_OK, 5'b10000},
        '{8'h00, 8'h00, V_BAD, 5'b11100}, '{8'h4A, 8'h00, V_BAD, 5'b11100},
        '{8'h88, 8'h00, V_BAD, 5'b01100}, '{8'hC0, 8'h00, V_BAD, 5'b01110}};
    logic [7:0] codes [5] = '{ILF_CMD_WARN, ILF_CMD_FAULT, ILF_CMD_ACT, ILF_CMD_OPT, 8'h33};
    logic [15:0] rstv [5] = '{16'h0000, 16'h0000, 16'h00C0, 16'h0000, 16'h0000};
    logic [15:0] wv [5] = '{16'h1234, 16'h5678, 16'hABCD, 16'hFF01, 16'hBEEF};
    logic [15:0] rb [5] = '{16'h1234, 16'h5678, 16'h00CD, 16'h0001, 16'h0000};
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    ilf_cmd_s cmd;
    logic [15:0] rd_data;
    logic [15:0] d;
    logic rd_valid, v, on;
    logic ctrl_on = 1'b1;
    logic clr_all = 1'b0;
    logic clr_bit = 1'b0;
    logic oth = 1'b0;
    ilf_lin_s vin = V_OK;
    logic [7:0] tunit = 8'h01;
    logic out_en, uv_warn, uv_fault, hybrid_ratio_regulation, latched;
    int num_errors = 0;
    int cmp_count = 0;
    int n;

    always #20 mclk = ~mclk;

    ilf_host host (.clk(mclk), .cmd(cmd), .rd_data(rd_data), .rd_valid(rd_valid));
    ilf_top #(.MS_CYCLES(MSC)) dut (.MCLK(mclk), .RESETN(rst_n), .CMD(cmd), .RD_DATA(rd_data),
        .RD_VALID(rd_valid), .VIN(vin), .CTRL_ON(ctrl_on), .CLEAR_FAULTS(clr_all),
        .CLEAR_UV_BIT(clr_bit), .OTHER_FAULT(oth), .TIME_UNIT_MS(tunit), .OUT_EN(out_en),
        .UV_WARN(uv_warn), .UV_FAULT(uv_fault), .HRR_SWITCH(hybrid_ratio_regulation), .LATCHED(latched));

    // ****************************************
    // Checks and helpers
    // ****************************************
    task automatic chk1(input string nm, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %b seen %b", nm, e, g);
        end
    endtask : chk1

    task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk16

    task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
        cmp_count++;
        if (g < lo || g > hi) begin
            num_errors++;
            $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask : chk_rng

    task automatic results();
        $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results

    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask : cyc

    // Short reset between cases so every case starts from the same state
    task automatic setup(input logic [7:0] act, input logic [7:0] opt);
        @(posedge mclk);
        rst_n <= 1'b0;
        vin <= V_OK;
        ctrl_on <= 1'b1;
        oth <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        host.write(ILF_CMD_WARN, 16'h0064);
        host.write(ILF_CMD_FAULT, 16'h0032);
        host.write(ILF_CMD_ACT, {8'h00, act});
        host.write(ILF_CMD_OPT, {8'h00, opt});
        cyc(2);
    endtask : setup

    // Cycles from a lasting fault until the output is held off, and any output restart
    task automatic meas(input logic [7:0] act, output int k, output logic seen);
        setup(act, 8'h00);
        @(posedge mclk);
        vin <= V_BAD;
        k = 0;
        seen = 1'b0;
        while (latched !== 1'b1 && k < 2000) begin
            @(posedge mclk);
            #1;
            k++;
            if (k > 2 && out_en !== 1'b0) seen = 1'b1;
        end
    endtask : meas

    // Longest case list runs some 4000 cycles; over seven times that means a hang
    initial begin
        #(40 * 30000);
        num_errors++;
        results();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        cyc(6);
        chk1("reset out_en", 1'b0, out_en);
        chk1("reset latched", 1'b0, latched);
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            host.read(codes[i], d, v);
            chk16("reset value", rstv[i], d);
            chk1("read valid", 1'b1, v);
            host.write(codes[i], wv[i]);
            host.read(codes[i], d, v);
            chk16("read back", rb[i], d);
        end
        $display("Test registers done");
        foreach (rows[i]) begin
            setup(rows[i].act, rows[i].opt);
            @(posedge mclk);
            vin <= rows[i].vin;
            cyc(2);
            chk1("out_en", rows[i].exp[4], out_en);
            chk1("uv_warn", rows[i].exp[3], uv_warn);
            chk1("uv_fault", rows[i].exp[2], uv_fault);
            chk1("latched", rows[i].exp[1], latched);
            chk1("hrr_switch", rows[i].exp[0], hybrid_ratio_regulation);
        end
        $display("Test table done");
        setup(8'h4A, 8'h00);
        @(posedge mclk);
        vin <= V_BAD;
        cyc(15);
        chk1("run-on out_en", 1'b1, out_en);
        cyc(6);
        chk1("run-on end out_en", 1'b0, out_en);
        $display("Test run-on done");
        for (int r = 0; r < 7; r++) begin
            meas({2'b10, 3'(r), 3'h2}, n, on);
            chk_rng("latch time", r * 16, (r == 0) ? 22 : r * 18 + 4, n);
            chk1("no output restart", 1'b0, on);
        end
        for (int k = 0; k < 8; k++) begin
            meas({5'b10001, 3'(k)}, n, on);
            chk_rng("delay time", MSC << k, (MSC << k) + 6, n);
        end
        @(posedge mclk);
        tunit <= 8'h03;
        meas(8'h89, n, on);
        chk_rng("unit time", 24, 30, n);
        @(posedge mclk);
        tunit <= 8'h00;
        meas(8'h88, n, on);
        chk_rng("zero unit time", 4, 10, n);
        @(posedge mclk);
        tunit <= 8'h01;
        $display("Test retry timing done");
        meas(8'hB8, n, on);
        chk_rng("retry forever", 2000, 2000, n);
        @(posedge mclk);
        vin <= V_OK;
        oth <= 1'b1;
        cyc(10);
        chk1("other fault out_en", 1'b0, out_en);
        @(posedge mclk);
        oth <= 1'b0;
        cyc(3);
        chk1("after other fault out_en", 1'b1, out_en);
        $display("Test retry forever done");
        for (int m = 0; m < 3; m++) begin
            meas(8'hC0, n, on);
            @(posedge mclk);
            vin <= V_OK;
            cyc(20);
            chk1("held latched", 1'b1, latched);
            chk1("held out_en", 1'b0, out_en);
            @(posedge mclk);
            clr_all <= (m == 0);
            clr_bit <= (m == 1);
            ctrl_on <= (m != 2);
            @(posedge mclk);
            clr_all <= 1'b0;
            clr_bit <= 1'b0;
            @(posedge mclk);
            ctrl_on <= 1'b1;
            cyc(3);
            chk1("cleared latched", 1'b0, latched);
            chk1("cleared out_en", 1'b1, out_en);
            if (m < 2) chk1("cleared uv_fault", 1'b0, uv_fault);
        end
        $display("Test clears done");
        results();
    end
endmodule : tb_ilf_top
